// ===== rtl/mcs_sequencer.sv
module mcs_sequencer
  import mcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic chan_clk,
  input wire logic req_instr,
  input wire logic req_exec,
  input wire logic req_overlap,
  input wire logic pre_ia_cur,
  input wire logic pre_ia_look,
  input wire logic skip_detect,
  input wire logic trap_pending,
  input wire logic end_op_signal,
  input wire logic end_op_trig,
  input wire logic lookahead_loaded,
  input wire logic one_cycle_xfer,
  input wire logic two_cycle_xfer,
  input wire logic master_stop,
  input wire logic halt_instr,
  input wire logic start_key,
  input wire logic diag_mode,
  input wire logic chan_trap_active,
  input wire logic store_channel_op,
  input wire logic b_demand,
  input wire logic retain_priority,
  input wire logic [ADDR_W-1:0] program_counter,
  input wire logic [ADDR_W-1:0] index_reg,
  input wire logic [WORD_W-1:0] bus_even,
  input wire logic [WORD_W-1:0] bus_odd,
  output mcs_cycle_t cycle_out,
  output logic b_cycle,
  output logic b_interrupt,
  output logic inhibit_logic,
  output logic odd_addr,
  output logic [ADDR_W-1:0] mem_addr_latch,
  output logic addr_strobe,
  output logic [ADDR_W-1:0] operand_addr_reg,
  output logic [ADDR_W-1:0] lookahead_addr,
  output logic [WORD_W-1:0] memory_data_reg
);
  // =======================================================
  // processor clock times
  logic [STEP_W-1:0] t_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      t_q <= '0;
    end else if (t_q == CPU_LAST) begin
      t_q <= '0;
    end else begin
      t_q <= t_q + 4'h1;
    end
  end
  // =======================================================
  // operator start key is a pin
  logic start_s1_q;
  logic start_s2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_s1_q <= 1'b0;
      start_s2_q <= 1'b0;
    end else begin
      start_s1_q <= start_key;
      start_s2_q <= start_s1_q;
    end
  end
  // =======================================================
  // cycle triggers
  logic i_q;
  logic e_q;
  logic l_q;
  logic ov_q;
  logic pre_q;
  logic pre_look_q;
  logic ia_q;
  logic cancel;
  logic ia_go;
  logic ia_next;
  assign cancel = skip_detect | trap_pending;
  // lookahead-initiated request waits for end of op
  assign ia_go = pre_q & (~pre_look_q | end_op_signal);
  assign ia_next = ia_go & ~cancel;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 1'b0;
      pre_look_q <= 1'b0;
    end else if (cancel) begin
      pre_q <= 1'b0;
      pre_look_q <= 1'b0;
    end else if (pre_ia_cur | pre_ia_look) begin
      pre_q <= 1'b1;
      pre_look_q <= pre_ia_look & ~pre_ia_cur;
    end else if (t_q == T_E0 && ia_go && !ov_q && !master_stop) begin
      pre_q <= 1'b0;
      pre_look_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ia_q <= 1'b0;
    end else if (master_stop) begin
      ia_q <= ia_q;
    end else if (t_q == T_E0) begin
      // an overlap fetch already under way owns the index adders, so wait
      ia_q <= ia_next & ~ov_q;
    end
  end

  // i and e decided at A5, logic and overlap one clock later
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      i_q <= 1'b0;
      e_q <= 1'b0;
    end else if (master_stop) begin
      i_q <= i_q;
      e_q <= e_q;
    end else if (t_q == T_A5) begin
      if (ia_q) begin
        i_q <= one_cycle_xfer;
        e_q <= ~one_cycle_xfer & ~two_cycle_xfer;
      end else begin
        i_q <= req_instr;
        e_q <= req_exec | ia_next;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      l_q <= 1'b0;
      ov_q <= 1'b0;
    end else if (master_stop) begin
      l_q <= l_q;
      ov_q <= ov_q;
    end else if (cancel) begin
      ov_q <= 1'b0;
      l_q <= l_q;
    end else if (t_q == T_A6) begin
      // logic cycle whenever neither i nor e was set at A5, unless a skip or trap cancel at A6 holds l_q
      l_q <= ~i_q & ~e_q;
      // overlap rides only on an execute cycle and never with
      // a pending indirect cycle (ia_next), both need the index adders at 5
      ov_q <= req_overlap & e_q & ~ia_next;
    end
  end
  // =======================================================
  // inhibit logic, set wins over start
  logic inh_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inh_q <= 1'b0;
    end else if (master_stop | halt_instr) begin
      inh_q <= 1'b1;
    end else if (start_s2_q) begin
      inh_q <= 1'b0;
    end
  end
  // =======================================================
  // channel domain
  logic [STEP_W-1:0] ct_q;
  logic hold_c1_q;
  logic hold_c2_q;
  logic bt_q;
  always_ff @(posedge chan_clk or negedge rst_n) begin
    if (!rst_n) begin
      ct_q <= '0;
    end else if (ct_q == CHN_LAST) begin
      ct_q <= '0;
    end else begin
      ct_q <= ct_q + 4'h1;
    end
  end

  always_ff @(posedge chan_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_c1_q <= 1'b0;
      hold_c2_q <= 1'b0;
    end else begin
      hold_c1_q <= chan_trap_active | store_channel_op;
      hold_c2_q <= hold_c1_q;
    end
  end

  // demand is assumed stable before channel time 9
  always_ff @(posedge chan_clk or negedge rst_n) begin
    if (!rst_n) begin
      bt_q <= 1'b0;
    end else if (ct_q == T_CH9) begin
      // retain priority bypasses the trap/store hold
      bt_q <= retain_priority | (b_demand & ~hold_c2_q);
    end
  end
  // =======================================================
  // buffer interrupt on the processor clock
  logic bt_s1_q;
  logic bt_s2_q;
  logic bint_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bt_s1_q <= 1'b0;
      bt_s2_q <= 1'b0;
    end else begin
      bt_s1_q <= bt_q;
      bt_s2_q <= bt_s1_q;
    end
  end

  // only sampled at 5, so channel phase sets one or two blocked cycles
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bint_q <= 1'b0;
    end else if (t_q == T_A5) begin
      bint_q <= bt_s2_q | master_stop;
    end
  end
  // =======================================================
  // gated outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_out <= CYCLE_RST;
      b_cycle <= 1'b0;
      b_interrupt <= 1'b0;
      inhibit_logic <= 1'b0;
    end else begin
      cycle_out.instr <= i_q & ~bint_q;
      cycle_out.exec <= e_q & ~bint_q;
      cycle_out.overlap <= ov_q & ~bint_q & ~inh_q;
      cycle_out.logic_c <= l_q & ~inh_q;
      cycle_out.indirect <= ia_q & ~bint_q;
      b_cycle <= bt_s2_q;
      b_interrupt <= bint_q;
      inhibit_logic <= inh_q;
    end
  end
  // =======================================================
  // indirect datapath
  logic [ADDR_W-1:0] gate_addr;
  logic [ADDR_W-1:0] adder_sum;
  logic odd_q;
  logic two_addr_q;
  assign gate_addr = end_op_trig ? lookahead_addr : operand_addr_reg;
  // two's complement subtract via complement and carry
  assign adder_sum = memory_data_reg[ADDR_LSB +: ADDR_W] + ~index_reg + CARRY_IN;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      odd_q <= 1'b0;
      memory_data_reg <= WORD_RST;
    end else if (ia_q) begin
      if (t_q == T_GATE) begin
        // diagnostic mode swaps the even/odd sense
        odd_q <= gate_addr[ADDR_LSB] ^ diag_mode;
      end
      if (t_q == T_E4) begin
        memory_data_reg <= odd_q ? bus_odd : bus_even;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      operand_addr_reg <= ADDR_RST;
      lookahead_addr <= ADDR_RST;
    end else if (ia_q && t_q == T_A5) begin
      operand_addr_reg <= adder_sum;
      if (!lookahead_loaded) begin
        lookahead_addr <= adder_sum;
      end
    end
  end
  // =======================================================
  // address latch gating, one address per strobe
  mcs_src_t src;
  always_comb begin
    src = SRC_NONE;
    if (ia_q && t_q == T_GATE) begin
      src = end_op_trig ? SRC_LOOK : SRC_OPER;
    end else if (ia_q && t_q == T_A6) begin
      src = SRC_OPER;
    end else if (two_addr_q && t_q == T_SEQ2) begin
      src = SRC_ADDER;
    end else if (ov_q && e_q && !lookahead_loaded && t_q == T_SEQ2) begin
      src = SRC_PC;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      two_addr_q <= 1'b0;
    end else if (t_q == T_A6) begin
      two_addr_q <= ia_q & one_cycle_xfer;
    end else if (t_q == T_SEQ2) begin
      two_addr_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_latch <= ADDR_RST;
      addr_strobe <= 1'b0;
      odd_addr <= 1'b0;
    end else begin
      addr_strobe <= (src != SRC_NONE) & ~master_stop;
      odd_addr <= odd_q;
      case (src)
        SRC_OPER: mem_addr_latch <= operand_addr_reg;
        SRC_LOOK: mem_addr_latch <= lookahead_addr;
        SRC_ADDER: mem_addr_latch <= adder_sum;
        SRC_PC: mem_addr_latch <= program_counter;
        default: mem_addr_latch <= mem_addr_latch;
      endcase
    end
  end
endmodule

// ===== common/mcs_pkg.sv
package mcs_pkg;
  // =======================================================
  // widths
  localparam int ADDR_W = 15;
  localparam int WORD_W = 36;
  localparam int STEP_W = 4;
  // =======================================================
  // clock times within one cycle
  localparam logic [STEP_W-1:0] CPU_LAST = 4'hb;
  localparam logic [STEP_W-1:0] CHN_LAST = 4'hb;
  localparam logic [STEP_W-1:0] T_E0 = 4'h0;
  localparam logic [STEP_W-1:0] T_GATE = 4'h1;
  localparam logic [STEP_W-1:0] T_E4 = 4'h4;
  localparam logic [STEP_W-1:0] T_A5 = 4'h5;
  localparam logic [STEP_W-1:0] T_A6 = 4'h6;
  localparam logic [STEP_W-1:0] T_SEQ2 = 4'h7;
  localparam logic [STEP_W-1:0] T_CH9 = 4'h9;
  // =======================================================
  // fetched word layout, bits 0-14 are the low field
  localparam int ADDR_LSB = 0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [WORD_W-1:0] WORD_RST = 36'h0;
  localparam logic [ADDR_W-1:0] CARRY_IN = 15'h0001;
  // =======================================================
  // gated cycle outputs travel together
  typedef struct packed {
    logic instr;
    logic exec;
    logic logic_c;
    logic overlap;
    logic indirect;
  } mcs_cycle_t;
  localparam mcs_cycle_t CYCLE_RST = '0;
  // =======================================================
  // source gated onto the address latch
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_OPER = 3'b001,
    SRC_LOOK = 3'b010,
    SRC_ADDER = 3'b011,
    SRC_PC = 3'b100
  } mcs_src_t;
endpackage

// ===== tb/mcs_sequencer_asserts.sv
module mcs_sequencer_asserts
  import mcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic master_stop,
  input wire logic halt_instr,
  input wire logic lookahead_loaded,
  input wire logic [WORD_W-1:0] bus_even,
  input wire logic [WORD_W-1:0] bus_odd,
  input wire mcs_cycle_t cycle_out,
  input wire logic b_cycle,
  input wire logic b_interrupt,
  input wire logic inhibit_logic,
  input wire logic addr_strobe,
  input wire logic odd_addr,
  input wire logic [ADDR_W-1:0] lookahead_addr,
  input wire logic [WORD_W-1:0] memory_data_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // cycle gating
  a_no_overlap_ia: assert property (!(cycle_out.overlap && cycle_out.indirect))
    else $error("overlap beside indirect cycle");
  a_overlap_has_exec: assert property (cycle_out.overlap |-> cycle_out.exec)
    else $error("overlap without exec");
  // one cycle of slack, though the cycle outputs are registered from bint_q on the same edge as b_interrupt
  a_bint_blocks: assert property (b_interrupt && $past(b_interrupt) |->
    !(cycle_out.instr || cycle_out.exec || cycle_out.overlap))
    else $error("cycle output during buffer block");
  a_inhibit_blocks: assert property (inhibit_logic && $past(inhibit_logic) |->
    !cycle_out.logic_c && !cycle_out.overlap)
    else $error("logic or overlap while inhibited");
  a_halt_inhibit: assert property (halt_instr |-> ##[1:3] inhibit_logic)
    else $error("halt did not inhibit");
  a_stop_inhibit: assert property (master_stop |-> ##[1:3] inhibit_logic)
    else $error("stop did not inhibit");
  a_stop_bint: assert property (master_stop [*8] |-> ##[0:6] b_interrupt)
    else $error("stop did not raise buffer block");
  a_bcycle_bint: assert property ($rose(b_cycle) |-> ##[0:13] b_interrupt)
    else $error("buffer block late");
  a_two_addr_max: assert property (addr_strobe ##1 addr_strobe |=> !addr_strobe)
    else $error("more than two addresses in a row");
  a_mdr_bus: assert property ($changed(memory_data_reg) |->
    memory_data_reg == ($past(odd_addr) ? $past(bus_odd) : $past(bus_even)))
    else $error("data register from wrong bus");
  a_look_copy: assert property ($changed(lookahead_addr) |-> !$past(lookahead_loaded))
    else $error("lookahead copied while loaded");
  c_bint: cover property ($rose(b_interrupt));
  c_ia: cover property ($rose(cycle_out.indirect));
  c_ovl: cover property (cycle_out.overlap);
  c_logic: cover property (cycle_out.logic_c && b_cycle);
endmodule

bind mcs_sequencer mcs_sequencer_asserts mcs_sequencer_asserts_i (
  .ref_clk, .rst_n, .master_stop, .halt_instr, .lookahead_loaded, .bus_even, .bus_odd,
  .cycle_out, .b_cycle, .b_interrupt, .inhibit_logic, .addr_strobe, .odd_addr,
  .lookahead_addr, .memory_data_reg
);

// ===== tb/mcs_channel_model.sv
module mcs_channel_model
  import mcs_pkg::*;
(
  input wire logic chan_clk,
  input wire logic rst_n,
  input wire logic want,
  input wire logic keep,
  output logic b_demand,
  output logic retain_priority
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [STEP_W-1:0] t_q;
  // ==========================================================
  // channel cycle and demand
  always_ff @(posedge chan_clk or negedge rst_n) begin
    if (!rst_n) t_q <= '0;
    else t_q <= (t_q == CHN_LAST) ? '0 : t_q + 4'h1;
  end
  // raised near channel time 3 and held past 9 so the sample never races
  always_ff @(posedge chan_clk or negedge rst_n) begin
    if (!rst_n) begin
      b_demand <= 1'b0;
      retain_priority <= 1'b0;
    end else if (t_q == 4'h3) begin
      b_demand <= want;
      retain_priority <= want & keep;
    end else if (t_q == 4'ha) begin
      b_demand <= 1'b0;
      retain_priority <= 1'b0;
    end
  end
endmodule

// ===== tb/test_cpu_machine_cycle_sequencer.sv
module test_cpu_machine_cycle_sequencer
  import mcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [4:0] in; mcs_cycle_t exp;} mcs_row_t;
  // inputs are {instr, exec, overlap, skip, trap}
  localparam mcs_row_t ROWS [6] = '{'{5'h10, 5'h10}, '{5'h08, 5'h08}, '{5'h0c, 5'h0a},
    '{5'h0e, 5'h08}, '{5'h0d, 5'h08}, '{5'h00, 5'h04}};
  logic ref_clk = 1'b0;
  logic chan_clk, rst_n, req_instr, req_exec, req_overlap, pre_ia_cur, pre_ia_look;
  logic skip_detect, trap_pending, end_op_signal, end_op_trig, lookahead_loaded;
  logic one_cycle_xfer, two_cycle_xfer, master_stop, halt_instr, start_key, diag_mode;
  logic chan_trap_active, store_channel_op, b_demand, retain_priority, want, keep;
  logic b_cycle, b_interrupt, inhibit_logic, odd_addr, addr_strobe;
  logic [ADDR_W-1:0] program_counter, index_reg, mem_addr_latch, operand_addr_reg;
  logic [ADDR_W-1:0] lookahead_addr;
  logic [WORD_W-1:0] bus_even, bus_odd, memory_data_reg;
  mcs_cycle_t cycle_out;
  mcs_cycle_t seen = '0;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [WORD_W-1:0] strobes = '0;
  mcs_sequencer mcs_sequencer_i (.ref_clk, .rst_n, .chan_clk, .req_instr, .req_exec,
    .req_overlap, .pre_ia_cur, .pre_ia_look, .skip_detect, .trap_pending, .end_op_signal,
    .end_op_trig, .lookahead_loaded, .one_cycle_xfer, .two_cycle_xfer, .master_stop,
    .halt_instr, .start_key, .diag_mode, .chan_trap_active, .store_channel_op, .b_demand,
    .retain_priority, .program_counter, .index_reg, .bus_even, .bus_odd, .cycle_out,
    .b_cycle, .b_interrupt, .inhibit_logic, .odd_addr, .mem_addr_latch, .addr_strobe,
    .operand_addr_reg, .lookahead_addr, .memory_data_reg);
  mcs_channel_model mcs_channel_model_i (.chan_clk, .rst_n, .want, .keep, .b_demand,
    .retain_priority);
  // ==========================================================
  // clocks, watchdog and helpers
  always #5 ref_clk = ~ref_clk;
  initial begin
    chan_clk = 1'b0;
    #7;
    forever #40 chan_clk = ~chan_clk;
  end
  // outputs are collected mid-cycle, clear of the edge that launches them
  always @(negedge ref_clk) begin
    seen = seen | cycle_out;
    if (addr_strobe === 1'b1) strobes++;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      $display("CHECK FAILED %0t timeout", $time);
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_f(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t flag %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_v(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t value %h exp %h", $time, g, e);
    end
  endtask
  task automatic start();
    start_key = 1'b1;
    tick(4);
    start_key = 1'b0;
    tick(36);
  endtask
  task automatic ia(input logic look);
    {pre_ia_cur, pre_ia_look} = look ? 2'b01 : 2'b10;
    tick(1);
    {pre_ia_cur, pre_ia_look} = 2'b00;
    tick(36);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    {req_instr, req_exec, req_overlap, pre_ia_cur, pre_ia_look, skip_detect, trap_pending,
      end_op_signal, end_op_trig, lookahead_loaded, one_cycle_xfer, two_cycle_xfer,
      master_stop, halt_instr, start_key, diag_mode, chan_trap_active, store_channel_op,
      want, keep} = '0;
    program_counter = 15'h0123;
    index_reg = 15'h0003;
    bus_even = 36'h000000010;
    bus_odd = 36'h000000020;
    tick(12);
    chk_v(WORD_W'({cycle_out, b_cycle, b_interrupt, inhibit_logic, odd_addr}), '0);
    chk_v(memory_data_reg | WORD_W'(mem_addr_latch), '0);
    rst_n = 1'b1;
    tick(2);
    $display("test reset done");
    foreach (ROWS[i]) begin
      {req_instr, req_exec, req_overlap, skip_detect, trap_pending} = ROWS[i].in;
      tick(36);
      chk_v(WORD_W'(cycle_out), WORD_W'(ROWS[i].exp));
    end
    $display("test rows done");
    halt_instr = 1'b1;
    tick(36);
    chk_f(inhibit_logic, 1'b1);
    chk_f(cycle_out.logic_c, 1'b0);
    halt_instr = 1'b0;
    start();
    chk_f(cycle_out.logic_c, 1'b1);
    {req_exec, master_stop} = 2'b11;
    tick(36);
    chk_f(b_interrupt, 1'b1);
    chk_v(WORD_W'({cycle_out, inhibit_logic}), WORD_W'(1'b1));
    master_stop = 1'b0;
    start();
    chk_f(cycle_out.exec, 1'b1);
    $display("test halt and stop done");
    for (int k = 0; k < 2; k++) begin
      {want, chan_trap_active, store_channel_op} = (k == 0) ? 3'b101 : 3'b110;
      tick(240);
      chk_f(b_cycle, 1'b0);
      {chan_trap_active, store_channel_op} = 2'b00;
      tick(240);
      chk_v(WORD_W'({b_cycle, b_interrupt, cycle_out.exec}), 36'h6);
      want = 1'b0;
      tick(240);
      chk_v(WORD_W'({b_interrupt, cycle_out.exec}), 36'h1);
    end
    // retain priority must get through even while a channel trap holds demands off
    {want, keep, req_exec, chan_trap_active} = 4'b1101;
    tick(240);
    chk_v(WORD_W'({b_cycle, cycle_out.logic_c}), 36'h3);
    {want, keep, chan_trap_active} = 3'b000;
    tick(240);
    $display("test buffer done");
    seen = '0;
    strobes = '0;
    ia(1'b0);
    chk_f(seen.exec, 1'b1);
    chk_v(memory_data_reg, bus_even);
    chk_v(WORD_W'({operand_addr_reg, lookahead_addr}), 36'h00006800d);
    chk_v(WORD_W'(mem_addr_latch), 36'h00000000d);
    chk_v(strobes, 36'h2);
    lookahead_loaded = 1'b1;
    ia(1'b0);
    chk_v(memory_data_reg, bus_odd);
    chk_v(WORD_W'({odd_addr, operand_addr_reg, lookahead_addr}), 36'h0400e800d);
    {diag_mode, one_cycle_xfer} = 2'b11;
    seen = '0;
    strobes = '0;
    ia(1'b0);
    chk_f(odd_addr, 1'b0);
    chk_f(seen.instr, 1'b1);
    chk_v(strobes, 36'h3);
    chk_v(WORD_W'(mem_addr_latch), 36'h00000000d);
    {diag_mode, one_cycle_xfer, end_op_trig, lookahead_loaded} = 4'h2;
    bus_odd = 36'h000000040;
    seen = '0;
    ia(1'b1);
    chk_f(seen.indirect, 1'b0);
    end_op_signal = 1'b1;
    tick(36);
    chk_v(memory_data_reg, bus_odd);
    chk_v(WORD_W'({operand_addr_reg, lookahead_addr}), 36'h0001e803d);
    {skip_detect, end_op_trig} = 2'b10;
    seen = '0;
    ia(1'b0);
    chk_f(seen.indirect, 1'b0);
    // instruction cycles all round, so a logic cycle can only come from the transfer
    {skip_detect, req_instr, two_cycle_xfer} = 3'b011;
    seen = '0;
    ia(1'b0);
    chk_f(seen.logic_c, 1'b1);
    {req_instr, two_cycle_xfer} = 2'b00;
    $display("test indirect done");
    results();
  end
endmodule
